// *** rtl/ncr_cfg.svh ***
// Constants for the negate, relative call and software reset executor
`ifndef NCR_CFG_SVH
`define NCR_CFG_SVH

// ==========================================
// Opcode fields
`define NCR_NEG_OPC        7'h36
`define NCR_NEG_OPC_HI     15
`define NCR_NEG_OPC_LO     9
`define NCR_ACC_BIT        8
`define NCR_CALL_OPC       5'h1B
`define NCR_CALL_OPC_HI    15
`define NCR_CALL_OPC_LO    11
`define NCR_CALL_OFS_W     11
`define NCR_RESET_WORD     16'h00FF

// ==========================================
// Addressing
`define NCR_INDEX_MAX      8'h5F
`define NCR_ACC_SPLIT      8'h60
`define NCR_ACC_HI_BANK    4'hF
`define NCR_ACC_LO_BANK    4'h0

// ==========================================
// Status flag positions and reset value
`define NCR_ST_C           0
`define NCR_ST_DC          1
`define NCR_ST_Z           2
`define NCR_ST_OV          3
`define NCR_ST_N           4
`define NCR_ST_RESET       5'h00

// ==========================================
// Timing
`define NCR_QUARTERS       4
`define NCR_PC_STEP        21'h000002

`endif

// *** rtl/ncr_pkg.sv ***
// Types for the negate, relative call and software reset executor
package ncr_pkg;

  typedef enum logic [2:0] {
    NCR_OP_NONE        = 3'b001,
    NEGATE_REGISTER_OP = 3'b010,
    RELATIVE_CALL_OP   = 3'b100
  } ncr_op_e;

  typedef enum logic [4:0] {
    NCR_S_IDLE  = 5'b00001,
    NCR_S_Q2    = 5'b00010,
    NCR_S_Q3    = 5'b00100,
    NCR_S_Q4    = 5'b01000,
    NCR_S_FLUSH = 5'b10000
  } ncr_state_e;

endpackage : ncr_pkg

// *** rtl/ncr_exec.sv ***
// Executes negate, relative call and software reset in quarter-cycle steps
// How it works
// (RL1) Negate register to two's complement, set flags
// (RL2) Access bit picks access bank or bank register
// (RL3) Extended set, low address: indexed literal offset
// (RL4) Write result back; one word, one cycle
// (RL5) Call pushes PC+2, jumps PC+2+2n
// (RL6) Call takes two cycles, second is empty
// (RL7) Reset instruction restores all master-clear state; here only status_r is cleared, the rest is left to the core via soft_reset_r
// (RL8) Reset starts in Q2, one word, one cycle
`timescale 1ns/1ps
`include "ncr_cfg.svh"

module ncr_exec
  import ncr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr,
  input  wire logic [20:0] instr_pc,
  input  wire logic [3:0]  bank_select_reg,
  input  wire logic        ext_set_en,
  input  wire logic [11:0] index_base,
  input  wire logic [7:0]  dm_rdata,
  output logic             busy_r,
  output logic [11:0]      dm_addr_r,
  output logic             dm_rd_r,
  output logic             dm_wr_r,
  output logic [7:0]       dm_wdata_r,
  output logic [4:0]       status_r,
  output logic             stack_push_r,
  output logic [20:0]      stack_top_entry_r,
  output logic             pc_load_r,
  output logic [20:0]      pc_target_r,
  output logic             soft_reset_r
);

  ncr_state_e  state_r;
  ncr_state_e  state_nxt;
  ncr_op_e     op_r;
  ncr_op_e     op_nxt;
  logic [1:0]  flush_cnt_r;
  logic        accept;
  logic        is_neg;
  logic        is_call;
  logic        is_reset;
  logic [7:0]  f_addr;
  logic [11:0] ea_nxt;
  logic [7:0]  neg_res;
  logic [20:0] ret_addr;
  logic [20:0] call_ofs;
  logic        take_neg;
  logic        take_call;
  logic        take_reset;
  logic        neg_wb;
  logic        call_load;

  // ==========================================
  // Decode
  assign accept   = instr_valid && (state_r == NCR_S_IDLE);
  assign is_neg   = instr[`NCR_NEG_OPC_HI:`NCR_NEG_OPC_LO] == `NCR_NEG_OPC;
  assign is_call  = instr[`NCR_CALL_OPC_HI:`NCR_CALL_OPC_LO] == `NCR_CALL_OPC;
  assign is_reset = instr == `NCR_RESET_WORD;
  assign f_addr   = instr[7:0];
  assign ret_addr = instr_pc + `NCR_PC_STEP;
  // Sign-extended word offset doubled into a byte offset
  assign call_ofs = {{9{instr[`NCR_CALL_OFS_W-1]}}, instr[`NCR_CALL_OFS_W-1:0], 1'b0};
  assign neg_res  = (~dm_rdata) + 8'h01;                                             // RL1

  assign take_neg   = accept && is_neg;
  assign take_call  = accept && is_call;
  assign take_reset = accept && is_reset;
  // Q3 of a running negate or call, one edge ahead of its Q4 pulse
  assign neg_wb     = (state_r == NCR_S_Q3) && (op_r == NEGATE_REGISTER_OP);
  assign call_load  = (state_r == NCR_S_Q3) && (op_r == RELATIVE_CALL_OP);

  // ==========================================
  // Effective data-memory address
  always_comb begin
    if (instr[`NCR_ACC_BIT]) begin
      ea_nxt = {bank_select_reg, f_addr};                                          // RL2
    end else if (ext_set_en && (f_addr <= `NCR_INDEX_MAX)) begin
      ea_nxt = index_base + {4'h0, f_addr};                                        // RL3
    end else if (f_addr < `NCR_ACC_SPLIT) begin
      ea_nxt = {`NCR_ACC_LO_BANK, f_addr};                                         // RL2
    end else begin
      ea_nxt = {`NCR_ACC_HI_BANK, f_addr};                                         // RL2
    end
  end

  // ==========================================
  // Quarter-cycle sequencer
  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    unique case (state_r)
      NCR_S_IDLE: begin
        if (accept && (is_neg || is_call || is_reset)) begin
          state_nxt = NCR_S_Q2;
          op_nxt    = is_neg ? NEGATE_REGISTER_OP : (is_call ? RELATIVE_CALL_OP : NCR_OP_NONE);
        end
      end
      NCR_S_Q2: begin
        state_nxt = NCR_S_Q3;
      end
      NCR_S_Q3: begin
        state_nxt = NCR_S_Q4;
      end
      NCR_S_Q4: begin
        state_nxt = (op_r == RELATIVE_CALL_OP) ? NCR_S_FLUSH : NCR_S_IDLE;         // RL6
      end
      NCR_S_FLUSH: begin
        if (flush_cnt_r == 2'(`NCR_QUARTERS - 1)) begin
          state_nxt = NCR_S_IDLE;
        end
      end
      default: begin
        state_nxt = NCR_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= NCR_S_IDLE;
      op_r    <= NCR_OP_NONE;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      busy_r  <= state_nxt != NCR_S_IDLE;
    end
  end

  // Empty second cycle of the call while the fetch refills
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flush_cnt_r <= 2'h0;
    end else if (state_r == NCR_S_FLUSH) begin
      flush_cnt_r <= flush_cnt_r + 2'h1;                                           // RL6
    end else begin
      flush_cnt_r <= 2'h0;
    end
  end

  // ==========================================
  // Data memory: read in Q2, write back in Q4
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dm_rd_r <= 1'b0;
      dm_wr_r <= 1'b0;
    end else begin
      dm_rd_r <= take_neg;
      dm_wr_r <= neg_wb;                                                           // RL4
    end
  end

  // Address is captured at decode and held through the write back
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dm_addr_r <= 12'h000;
    end else if (take_neg) begin
      dm_addr_r <= ea_nxt;                                                         // RL4
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dm_wdata_r <= 8'h00;
    end else if (neg_wb) begin
      dm_wdata_r <= neg_res;                                                       // RL4
    end
  end

  // ==========================================
  // Status flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_r <= `NCR_ST_RESET;
    end else if (take_reset) begin
      status_r <= `NCR_ST_RESET;                                                   // RL7
    end else if (neg_wb) begin
      status_r[`NCR_ST_N]  <= neg_res[7];                                          // RL1
      status_r[`NCR_ST_Z]  <= neg_res == 8'h00;                                    // RL1
      status_r[`NCR_ST_C]  <= dm_rdata == 8'h00;                                   // RL1
      status_r[`NCR_ST_DC] <= dm_rdata[3:0] == 4'h0;                               // RL1
      status_r[`NCR_ST_OV] <= dm_rdata == 8'h80;                                   // RL1
    end
  end

  // ==========================================
  // Relative call: push in Q2, load PC in Q4
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stack_push_r <= 1'b0;
      pc_load_r    <= 1'b0;
    end else begin
      stack_push_r <= take_call;                                                   // RL5
      pc_load_r    <= call_load;                                                   // RL6
    end
  end

  // Return address and target are held until the next call
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stack_top_entry_r <= 21'h000000;
      pc_target_r       <= 21'h000000;
    end else if (take_call) begin
      stack_top_entry_r <= ret_addr;                                               // RL5
      pc_target_r       <= ret_addr + call_ofs;                                    // RL5
    end
  end

  // ==========================================
  // Software reset request in Q2; the core clears all other state on it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      soft_reset_r <= 1'b0;
    end else begin
      soft_reset_r <= take_reset;                                                  // RL8
    end
  end

endmodule : ncr_exec

// *** test/ncr_exec_checker.sv ***
// Port assertions for the executor
`timescale 1ns/1ps
`include "ncr_cfg.svh"
module ncr_exec_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        instr_valid,
  input wire logic [15:0] instr,
  input wire logic [20:0] instr_pc,
  input wire logic [3:0]  bank_select_reg,
  input wire logic        ext_set_en,
  input wire logic [11:0] index_base,
  input wire logic [7:0]  dm_rdata,
  input wire logic        busy_r,
  input wire logic [11:0] dm_addr_r,
  input wire logic        dm_rd_r,
  input wire logic        dm_wr_r,
  input wire logic [7:0]  dm_wdata_r,
  input wire logic [4:0]  status_r,
  input wire logic        stack_push_r,
  input wire logic [20:0] stack_top_entry_r,
  input wire logic        pc_load_r,
  input wire logic [20:0] pc_target_r,
  input wire logic        soft_reset_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence neg_take;
    instr_valid && !busy_r && instr[15:9] == `NCR_NEG_OPC;
  endsequence
  sequence call_take;
    instr_valid && !busy_r && instr[15:11] == `NCR_CALL_OPC;
  endsequence
  chk_read_after_take: assert property (neg_take |=> dm_rd_r && busy_r)
    else $error("no read");
  chk_bank_address: assert property (neg_take ##0 instr[8]
    |=> dm_addr_r == {$past(bank_select_reg), $past(instr[7:0])}) else $error("bad address");
  chk_index_address: assert property (neg_take ##0 (!instr[8] && ext_set_en && instr[7:0] <= `NCR_INDEX_MAX)
    |=> dm_addr_r == $past(index_base) + {4'h0, $past(instr[7:0])}) else $error("bad indexed address");
  chk_write_two_later: assert property (dm_rd_r |=> !dm_rd_r ##1 dm_wr_r ##1 !dm_wr_r && !busy_r)
    else $error("bad write timing");
  chk_neg_value: assert property (dm_wr_r |-> dm_wdata_r == 8'(~$past(dm_rdata) + 8'h01)
    && status_r[`NCR_ST_Z] == (dm_wdata_r == 8'h00)) else $error("bad negate");
  chk_call_push: assert property (call_take
    |=> stack_push_r && stack_top_entry_r == $past(instr_pc) + `NCR_PC_STEP) else $error("bad push");
  chk_call_target: assert property (stack_push_r
    |-> pc_target_r == stack_top_entry_r + {{9{$past(instr[10])}}, $past(instr[10:0]), 1'b0})
    else $error("bad target");
  chk_call_cycles: assert property (stack_push_r |-> ##2 pc_load_r ##1 busy_r[*4] ##1 !busy_r)
    else $error("bad call timing");
  chk_reset_flags: assert property (soft_reset_r |-> status_r == `NCR_ST_RESET)
    else $error("flags not reset");
  chk_reset_quick: assert property (soft_reset_r |=> !soft_reset_r ##2 !busy_r)
    else $error("bad reset timing");
endmodule : ncr_exec_checker

// *** test/testbench.sv ***
// Directed bench for the executor
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, ext_set_en = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [20:0] instr_pc = 21'h000000;
  logic [3:0]  bank_select_reg = 4'h5;
  logic [11:0] index_base = 12'hFF0;
  logic [7:0]  dm_rdata = 8'h00;
  logic        busy_r, dm_rd_r, dm_wr_r, stack_push_r, pc_load_r, soft_reset_r;
  logic [11:0] dm_addr_r;
  logic [7:0]  dm_wdata_r;
  logic [4:0]  status_r;
  logic [20:0] stack_top_entry_r, pc_target_r;
  int          failures = 0, compares = 0, cycles = 0;
  always #12.5 clk = ~clk;
  ncr_exec DUT (.clk, .rst_n, .instr_valid, .instr, .instr_pc, .bank_select_reg, .ext_set_en,
    .index_base, .dm_rdata, .busy_r, .dm_addr_r, .dm_rd_r, .dm_wr_r, .dm_wdata_r, .status_r,
    .stack_push_r, .stack_top_entry_r, .pc_load_r, .pc_target_r, .soft_reset_r);
  task check(string n, logic [20:0] s, logic [20:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task conclude;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      conclude;
    end
  end
  task go(logic [15:0] w, logic [20:0] pc);
    @(negedge clk);
    instr = w;
    instr_pc = pc;
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
  endtask : go
  task neg(logic [15:0] w, logic [7:0] d, logic [11:0] ea, logic [7:0] res, logic [4:0] st);
    dm_rdata = d;
    go(w, 21'h000100);
    check("rd", dm_rd_r, 1'b1);
    check("addr", dm_addr_r, ea);
    repeat (2) @(negedge clk);
    check("wr", dm_wr_r, 1'b1);
    check("res", dm_wdata_r, res);
    check("flags", status_r, st);
    @(negedge clk);
    check("done", busy_r, 1'b0);
  endtask : neg
  task call(logic [10:0] n, logic [20:0] pc);
    go({5'h1B, n}, pc);
    check("push", stack_push_r, 1'b1);
    check("tos", stack_top_entry_r, pc + 21'h000002);
    check("tgt", pc_target_r, pc + 21'h000002 + {{9{n[10]}}, n, 1'b0});
    repeat (2) @(negedge clk);
    check("load", pc_load_r, 1'b1);
    repeat (4) @(negedge clk);
    check("flush", busy_r, 1'b1);
    @(negedge clk);
    check("free", busy_r, 1'b0);
  endtask : call
  task soft_reset;
    go(16'h00FF, 21'h000200);
    check("rst", soft_reset_r, 1'b1);
    check("st", status_r, 5'h00);
    repeat (3) @(negedge clk);
    check("end", busy_r, 1'b0);
  endtask : soft_reset
  task refuse;
    go(16'hD3FF, 21'h000300);
    check("skip", busy_r, 1'b0);
    check("nopush", stack_push_r, 1'b0);
    @(negedge clk);
    instr = 16'h00FF;
    instr_valid = 1'b1;
    @(negedge clk);
    instr = 16'hDBFF;
    repeat (3) begin
      check("held", stack_push_r, 1'b0);
      @(negedge clk);
    end
    instr_valid = 1'b0;
    check("ready", busy_r, 1'b0);
  endtask : refuse
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    neg(16'h6D3A, 8'h3A, 12'h53A, 8'hC6, 5'h10);
    neg(16'h6C10, 8'h01, 12'h010, 8'hFF, 5'h10);
    ext_set_en = 1'b1;
    neg(16'h6C5F, 8'h00, 12'h04F, 8'h00, 5'h07);
    neg(16'h6C60, 8'h80, 12'hF60, 8'h80, 5'h1A);
    call(11'h400, 21'h001000);
    call(11'h3FF, 21'h1FFF00);
    soft_reset;
    refuse;
    conclude;
  end
endmodule : testbench
bind ncr_exec ncr_exec_checker u_chk (.clk, .rst_n, .instr_valid, .instr, .instr_pc, .bank_select_reg, .ext_set_en,
  .index_base, .dm_addr_r,
  .dm_rdata, .busy_r, .dm_rd_r, .dm_wr_r, .dm_wdata_r, .status_r, .stack_push_r, .stack_top_entry_r,
  .pc_load_r, .pc_target_r, .soft_reset_r);
